/* rtl/idf_dma_ctrl.sv */
module idf_dma_ctrl
    import idf_pkg::*;
(
    input wire logic sys_clk,
    input wire logic srst,
    idf_flow_if.dma flow,
    input wire logic cfg_wr,
    input wire logic [3:0] cfg_chan,
    input wire logic cfg_hw_mode,
    input wire logic [3:0] cfg_dev,
    input wire logic cfg_dev_is_src,
    input wire logic [1:0] cfg_size,
    input wire logic [ADDR_W-1:0] cfg_mem_addr,
    input wire logic [ADDR_W-1:0] cfg_dev_addr,
    input wire logic [CNT_W-1:0] cfg_limit,
    input wire logic fw_go,
    input wire logic fw_abort,
    input wire logic sleep_req,
    output logic sleep_ack,
    output logic [NUM_CHAN-1:0] chan_run,
    output logic [NUM_CHAN-1:0] chan_irq,
    output logic bus_req,
    output logic bus_we,
    output logic [ADDR_W-1:0] bus_addr,
    output logic [1:0] bus_size,
    output logic [DATA_W-1:0] bus_wdata,
    input wire logic bus_ack,
    input wire logic [DATA_W-1:0] bus_rdata
);

    // ----------------------------------------
    // Channel state
    // ----------------------------------------
    logic [NUM_CHAN-1:0] hw_mode;
    logic [NUM_CHAN-1:0] dev_is_src;
    logic [3:0] flow_dev [NUM_CHAN];
    logic [1:0] pkt_size [NUM_CHAN];
    logic [ADDR_W-1:0] mem_addr [NUM_CHAN];
    logic [ADDR_W-1:0] dev_addr [NUM_CHAN];
    logic [CNT_W-1:0] remain [NUM_CHAN];
    logic [NUM_CHAN-1:0] chan_done;
    logic [NUM_CHAN-1:0] eligible;
    logic [NUM_CHAN-1:0] end_ev;
    logic [NUM_DEV-1:0] done_q;

    // ----------------------------------------
    // Engine state
    // ----------------------------------------
    idf_state_t state;
    logic [3:0] cur;
    logic [3:0] pick;
    logic pick_valid;
    logic pkt_fin;

    assign pkt_fin = (state == ST_WRITE) && bus_ack;
    assign chan_irq = chan_done;
    assign flow.done = done_q;

    // Which channels may move a packet now
    always_comb begin
        for (int i = 0; i < NUM_CHAN; i++) begin
            // Firmware run bit, plus the selected port's request in hardware mode
            eligible[i] = chan_run[i] && !end_ev[i] && (!hw_mode[i] || flow.req[flow_dev[i]]);
        end
    end

    // End of transfer per channel
    always_comb begin
        for (int i = 0; i < NUM_CHAN; i++) begin
            end_ev[i] = chan_run[i] && (
                (fw_abort && cfg_chan == 4'(i)) ||
                (hw_mode[i] && flow.term[flow_dev[i]]) ||
                (pkt_fin && cur == 4'(i) &&
                 remain[i] <= CNT_W'(idf_size_bytes(pkt_size[i]))));
        end
    end

    // Round robin pick of the next channel after the last served one
    always_comb begin
        logic [3:0] idx;
        idx = 4'h0;
        pick = cur;
        pick_valid = 1'b0;
        for (int k = 1; k <= NUM_CHAN; k++) begin
            idx = cur + 4'(k);
            if (!pick_valid && eligible[idx]) begin
                pick = idx;
                pick_valid = 1'b1;
            end
        end
    end

    // ----------------------------------------
    // Packet engine
    // ----------------------------------------

    // Read from source then write to destination, one packet at a time
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            state <= ST_IDLE;
            cur <= 4'h0;
            bus_req <= 1'b0;
            bus_we <= 1'b0;
            bus_addr <= '0;
            bus_size <= SIZE_1;
            bus_wdata <= '0;
        end else begin
            case (state)
                ST_IDLE: begin
                    if (pick_valid) begin
                        cur <= pick;
                        bus_req <= 1'b1;
                        bus_we <= 1'b0;
                        bus_size <= pkt_size[pick];
                        // Source is the peripheral or the memory side
                        bus_addr <= dev_is_src[pick] ? dev_addr[pick] : mem_addr[pick];
                        state <= ST_READ;
                    end
                end
                ST_READ: begin
                    if (bus_ack) begin
                        bus_wdata <= bus_rdata;
                        bus_we <= 1'b1;
                        // Same size code for the write keeps byte counts equal
                        bus_addr <= dev_is_src[cur] ? mem_addr[cur] : dev_addr[cur];
                        state <= ST_WRITE;
                    end
                end
                ST_WRITE: begin
                    if (bus_ack) begin
                        bus_req <= 1'b0;
                        bus_we <= 1'b0;
                        state <= ST_END;
                    end
                end
                ST_END: begin
                    state <= ST_IDLE;
                end
                default: begin
                    state <= ST_IDLE;
                    bus_req <= 1'b0;
                end
            endcase
        end
    end

    // ----------------------------------------
    // Channel configuration and progress
    // ----------------------------------------

    // Load settings, run bit, count and address advance
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            hw_mode <= '0;
            dev_is_src <= '0;
            chan_run <= '0;
            for (int i = 0; i < NUM_CHAN; i++) begin
                flow_dev[i] <= 4'h0;
                pkt_size[i] <= SIZE_1;
                mem_addr[i] <= '0;
                dev_addr[i] <= '0;
                remain[i] <= '0;
            end
        end else begin
            for (int i = 0; i < NUM_CHAN; i++) begin
                // Settings only change while the channel is stopped
                if (cfg_wr && cfg_chan == 4'(i) && !chan_run[i]) begin
                    hw_mode[i] <= cfg_hw_mode;
                    flow_dev[i] <= cfg_dev;
                    dev_is_src[i] <= cfg_dev_is_src;
                    pkt_size[i] <= idf_size_limit(cfg_size, cfg_dev);
                    mem_addr[i] <= cfg_mem_addr;
                    dev_addr[i] <= cfg_dev_addr;
                    remain[i] <= cfg_limit;
                end
                if (pkt_fin && cur == 4'(i)) begin
                    mem_addr[i] <= mem_addr[i] + ADDR_W'(idf_size_bytes(pkt_size[i]));
                    remain[i] <= (remain[i] > CNT_W'(idf_size_bytes(pkt_size[i])))
                                 ? remain[i] - CNT_W'(idf_size_bytes(pkt_size[i])) : '0;
                end
                // Ending wins over a go in the same cycle
                if (end_ev[i]) begin
                    chan_run[i] <= 1'b0;
                end else if (fw_go && cfg_chan == 4'(i) && remain[i] != '0) begin
                    chan_run[i] <= 1'b1;
                end
            end
        end
    end

    // Sticky done status; a new ending beats a clear in the same cycle
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            chan_done <= '0;
        end else begin
            for (int i = 0; i < NUM_CHAN; i++) begin
                if (end_ev[i]) begin
                    chan_done[i] <= 1'b1;
                end else if ((cfg_wr || fw_go) && cfg_chan == 4'(i)) begin
                    chan_done[i] <= 1'b0;
                end
            end
        end
    end

    // One cycle done pulse to the pacing port of an ending channel
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            done_q <= '0;
        end else begin
            done_q <= '0;
            for (int i = 0; i < NUM_CHAN; i++) begin
                if (end_ev[i] && hw_mode[i]) begin
                    done_q[flow_dev[i]] <= 1'b1;
                end
            end
        end
    end

    // Sleep granted only with no channel running and the engine idle
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            sleep_ack <= 1'b0;
        end else begin
            sleep_ack <= sleep_req && (chan_run == '0) && (state == ST_IDLE) && !pick_valid;
        end
    end

endmodule

/* rtl/idf_flow_if.sv */
// Request ports between the controller and its flow-master peripherals
interface idf_flow_if;
    import idf_pkg::*;
    logic [NUM_DEV-1:0] req;
    logic [NUM_DEV-1:0] term;
    logic [NUM_DEV-1:0] done;

    modport dma (input req, input term, output done);
    modport periph (output req, output term, input done);
endinterface

/* rtl/idf_periph.sv */
// Flow-master side: sixteen request ports toward the controller
module idf_periph
    import idf_pkg::*;
(
    input wire logic sys_clk,
    input wire logic srst,
    idf_flow_if.periph flow,
    input wire logic [NUM_DEV-1:0] want_pkt,
    input wire logic [NUM_DEV-1:0] stop_xfer,
    output logic [3:0] slave_port_finish,
    output logic [3:0] master_port_finish,
    output logic [7:0] pair_finish
);

    // ----------------------------------------
    // Request and terminate drivers
    // ----------------------------------------
    logic [NUM_DEV-1:0] req_q;
    logic [NUM_DEV-1:0] term_q;

    assign flow.req = req_q;
    assign flow.term = term_q;

    // Request follows the wish for packets, masked by stop_xfer; terminate is stop_xfer delayed by one cycle on ports below FIRST_REQ_ONLY_DEV
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            req_q <= '0;
            term_q <= '0;
        end else begin
            req_q <= want_pkt & ~stop_xfer;
            for (int d = 0; d < NUM_DEV; d++) begin
                // Request-only ports never terminate
                term_q[d] <= stop_xfer[d] && (4'(d) < FIRST_REQ_ONLY_DEV);
            end
        end
    end

    // ----------------------------------------
    // Done capture per port
    // ----------------------------------------

    // Even ports of the lower half are serial slaves, odd ones serial masters, upper half pairs
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            slave_port_finish <= '0;
            master_port_finish <= '0;
            pair_finish <= '0;
        end else begin
            for (int b = 0; b < 4; b++) begin
                slave_port_finish[b] <= flow.done[2*b];
                master_port_finish[b] <= flow.done[2*b+1];
            end
            pair_finish <= flow.done[NUM_DEV-1:FIRST_PAIR_DEV];
        end
    end

endmodule

/* rtl/idf_pkg.sv */
package idf_pkg;

    // ----------------------------------------
    // Sizes of the controller
    // ----------------------------------------
    localparam int NUM_CHAN = 16;
    localparam int NUM_DEV = 16;
    localparam int ADDR_W = 32;
    localparam int DATA_W = 32;
    localparam int CNT_W = 16;

    // ----------------------------------------
    // Packet size codes and device capability
    // ----------------------------------------
    localparam logic [1:0] SIZE_1 = 2'h0;
    localparam logic [1:0] SIZE_2 = 2'h1;
    localparam logic [1:0] SIZE_4 = 2'h2;
    // Largest packet each request port handles; plain defaults
    localparam logic [1:0] DEV_MAX_SIZE [NUM_DEV] = '{
        SIZE_1, SIZE_1, SIZE_1, SIZE_1, SIZE_1, SIZE_1, SIZE_1, SIZE_1,
        SIZE_1, SIZE_1, SIZE_4, SIZE_4, SIZE_4, SIZE_4, SIZE_4, SIZE_4
    };
    // Ports from here up are transmit and receive pairs
    localparam logic [3:0] FIRST_PAIR_DEV = 4'h8;
    // Ports at and above this have no terminate line
    localparam logic [3:0] FIRST_REQ_ONLY_DEV = 4'hc;

    // ----------------------------------------
    // Engine states
    // ----------------------------------------
    typedef enum logic [3:0] {
        ST_IDLE = 4'h1,
        ST_READ = 4'h2,
        ST_WRITE = 4'h4,
        ST_END = 4'h8
    } idf_state_t;

    // Byte count of a size code
    function automatic logic [2:0] idf_size_bytes(input logic [1:0] code);
        case (code)
            SIZE_1: idf_size_bytes = 3'h1;
            SIZE_2: idf_size_bytes = 3'h2;
            default: idf_size_bytes = 3'h4;
        endcase
    endfunction

    // Smaller of the asked size and what the port supports
    function automatic logic [1:0] idf_size_limit(input logic [1:0] asked, input logic [3:0] dev);
        idf_size_limit = (asked > DEV_MAX_SIZE[dev]) ? DEV_MAX_SIZE[dev] : asked;
    endfunction

endpackage

/* verification/idf_flow_sva.sv */
// ----------------------------------------
// Checks on the request ports between the two ends
// ----------------------------------------
module idf_flow_sva
    import idf_pkg::*;
(
    input wire logic sys_clk,
    input wire logic srst,
    input wire logic [NUM_DEV-1:0] req,
    input wire logic [NUM_DEV-1:0] term,
    input wire logic [NUM_DEV-1:0] done,
    input wire logic [NUM_CHAN-1:0] chan_run,
    input wire logic [NUM_CHAN-1:0] chan_irq,
    input wire logic [3:0] slave_port_finish,
    input wire logic [3:0] master_port_finish,
    input wire logic [7:0] pair_finish
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (srst);

    // A finish pulse on any port, and the channel ending beside it
    sequence s_done;
        |done;
    endsequence
    sequence s_irq_rise;
        |(chan_irq & ~$past(chan_irq));
    endsequence
    sequence s_run_fall;
        |($past(chan_run) & ~chan_run);
    endsequence

    property p_done_pulse;
        s_done |=> (done & $past(done)) == 16'h0;
    endproperty
    a_done_pulse: assert property (p_done_pulse) else $error("done held over one cycle");
    property p_done_irq;
        s_done |-> s_irq_rise;
    endproperty
    a_done_irq: assert property (p_done_irq) else $error("done without status rise");
    property p_done_run;
        s_done |-> s_run_fall;
    endproperty
    a_done_run: assert property (p_done_run) else $error("done without channel end");
    property p_term_pulse;
        |term |=> (term & $past(term)) == 16'h0;
    endproperty
    a_term_pulse: assert property (p_term_pulse) else $error("terminate held");
    property p_term_hi;
        term[15:12] == 4'h0;
    endproperty
    a_term_hi: assert property (p_term_hi) else $error("terminate on request only port");
    property p_slave_fin;
        1'b1 |=> slave_port_finish == $past({done[6], done[4], done[2], done[0]});
    endproperty
    a_slave_fin: assert property (p_slave_fin) else $error("slave finish mismatch");
    property p_master_fin;
        1'b1 |=> master_port_finish == $past({done[7], done[5], done[3], done[1]});
    endproperty
    a_master_fin: assert property (p_master_fin) else $error("master finish mismatch");
    property p_pair_fin;
        1'b1 |=> pair_finish == $past(done[15:8]);
    endproperty
    a_pair_fin: assert property (p_pair_fin) else $error("pair finish mismatch");
endmodule

/* verification/internal_dma_flow_control_tb.sv */
module internal_dma_flow_control_tb;
    timeunit 1ns;
    timeprecision 1ns;
    import idf_pkg::*;
    logic sys_clk = 1'b0, srst = 1'b1, cfg_wr = 1'b0, cfg_hw_mode = 1'b0, cfg_dev_is_src = 1'b0;
    logic fw_go = 1'b0, fw_abort = 1'b0, sleep_req = 1'b0, bus_ack = 1'b0;
    logic sleep_ack, bus_req, bus_we;
    logic [1:0] cfg_size = 2'h0, bus_size;
    logic [3:0] cfg_chan = 4'h0, cfg_dev = 4'h0, slave_port_finish, master_port_finish;
    logic [7:0] pair_finish;
    logic [15:0] cfg_limit = 16'h0, want_pkt = 16'h0, stop_xfer = 16'h0, chan_run, chan_irq;
    logic [31:0] cfg_mem_addr = 32'h0, cfg_dev_addr = 32'h4000_1000, bus_rdata = 32'h0;
    logic [31:0] bus_addr, bus_wdata, rd;
    logic [34:0] e;
    logic [34:0] exq[$];
    int n_fail = 0, compares = 0;
    int dn[16];

    idf_flow_if flow();
    idf_dma_ctrl u_idf_dma_ctrl(.sys_clk, .srst, .flow(flow.dma), .cfg_wr, .cfg_chan, .cfg_hw_mode,
        .cfg_dev, .cfg_dev_is_src, .cfg_size, .cfg_mem_addr, .cfg_dev_addr, .cfg_limit, .fw_go,
        .fw_abort, .sleep_req, .sleep_ack, .chan_run, .chan_irq, .bus_req, .bus_we, .bus_addr,
        .bus_size, .bus_wdata, .bus_ack, .bus_rdata);
    idf_periph u_idf_periph(.sys_clk, .srst, .flow(flow.periph), .want_pkt, .stop_xfer,
        .slave_port_finish, .master_port_finish, .pair_finish);
    idf_flow_sva u_sva(.sys_clk, .srst, .req(flow.req), .term(flow.term), .done(flow.done),
        .chan_run, .chan_irq, .slave_port_finish, .master_port_finish, .pair_finish);

    always #5 sys_clk = ~sys_clk;

    // ----------------------------------------
    // Shared tasks and the transfer model
    // ----------------------------------------
    task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            n_fail++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    function automatic logic [31:0] bmask(input logic [1:0] c);
        bmask = (c == 2'h0) ? 32'hff : (c == 2'h1) ? 32'hffff : 32'hffff_ffff;
    endfunction

    // Configure, start, and queue the expected read and write of every packet
    task start(input logic [3:0] ch, input logic [3:0] dev, input logic hw, input logic src,
               input logic [1:0] sz, input int lim, input logic [31:0] m);
        logic [1:0] eff;
        // Asked size capped by what the pacing port handles
        eff = (sz > DEV_MAX_SIZE[dev]) ? DEV_MAX_SIZE[dev] : sz;
        @(posedge sys_clk);
        cfg_chan <= ch;
        cfg_dev <= dev;
        cfg_hw_mode <= hw;
        cfg_dev_is_src <= src;
        cfg_size <= sz;
        cfg_limit <= lim[15:0];
        cfg_mem_addr <= m;
        cfg_wr <= 1'b1;
        @(posedge sys_clk);
        cfg_wr <= 1'b0;
        fw_go <= 1'b1;
        @(posedge sys_clk);
        fw_go <= 1'b0;
        for (int k = 0; k * (1 << eff) < lim; k++) begin
            exq.push_back({1'b0, eff, src ? cfg_dev_addr : m + k * (1 << eff)});
            exq.push_back({1'b1, eff, src ? m + k * (1 << eff) : cfg_dev_addr});
        end
    endtask

    // Wait for the run bit to fall and the packet in flight to finish
    task wait_idle(input int ch);
        int t;
        t = 0;
        @(posedge sys_clk);
        while ((chan_run[ch] !== 1'b0 || bus_req !== 1'b0) && t < 3000) begin
            @(posedge sys_clk);
            t++;
        end
        if (t >= 3000)
            n_fail++;
        @(posedge sys_clk);
    endtask

    task summarize;
        if (n_fail == 0 && compares > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // Memory side: acknowledges after a random stall
    always @(posedge sys_clk) begin
        bus_ack <= bus_req && !bus_ack && ($urandom % 3 != 0);
        bus_rdata <= $urandom;
    end

    // Compare every bus access with the model, count finish pulses
    always @(posedge sys_clk) begin
        if (bus_req === 1'b1 && bus_ack === 1'b1) begin
            if (exq.size() == 0) begin
                chk("extra access", 32'h1, 32'h0);
            end else begin
                e = exq.pop_front();
                chk("bus_we", {31'h0, bus_we}, {31'h0, e[34]});
                chk("bus_size", {30'h0, bus_size}, {30'h0, e[33:32]});
                chk("bus_addr", bus_addr, e[31:0]);
                if (!bus_we)
                    rd = bus_rdata;
                else
                    chk("bus_wdata", bus_wdata & bmask(e[33:32]), rd & bmask(e[33:32]));
            end
        end
        for (int i = 0; i < 16; i++)
            if (flow.done[i] === 1'b1)
                dn[i]++;
    end

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    initial begin
        void'($urandom(16516));
        repeat (10) @(posedge sys_clk);
        srst <= 1'b0;
        // Firmware paced, every packet size, limit not a multiple of four
        for (int s = 0; s < 3; s++) begin
            start(s[3:0], 4'ha, 1'b0, 1'b0, s[1:0], 10, 32'h2000_0100);
            wait_idle(s);
            chk("fw irq", {31'h0, chan_irq[s]}, 32'h1);
        end
        chk("fw done", 32'(dn[10]), 32'h0);
        // Paced by port 2, size capped to one byte, port is source
        want_pkt[2] <= 1'b1;
        start(4'h3, 4'h2, 1'b1, 1'b1, 2'h2, 3, 32'h2000_0200);
        wait_idle(3);
        want_pkt <= 16'h0;
        chk("port2 done", 32'(dn[2]), 32'h1);
        // Paced by port 11, ended early by its terminate
        want_pkt[11] <= 1'b1;
        start(4'h4, 4'hb, 1'b1, 1'b0, 2'h2, 400, 32'h2000_0300);
        repeat (20) @(posedge sys_clk);
        stop_xfer[11] <= 1'b1;
        @(posedge sys_clk);
        stop_xfer[11] <= 1'b0;
        wait_idle(4);
        want_pkt <= 16'h0;
        exq.delete();
        chk("port11 done", 32'(dn[11]), 32'h1);
        chk("term run", {31'h0, chan_run[4]}, 32'h0);
        // Firmware abort while sleep is requested
        sleep_req <= 1'b1;
        start(4'h5, 4'h0, 1'b0, 1'b0, 2'h0, 400, 32'h2000_0400);
        repeat (10) @(posedge sys_clk);
        chk("sleep busy", {31'h0, sleep_ack}, 32'h0);
        fw_abort <= 1'b1;
        @(posedge sys_clk);
        fw_abort <= 1'b0;
        wait_idle(5);
        exq.delete();
        repeat (4) @(posedge sys_clk);
        chk("sleep idle", {31'h0, sleep_ack}, 32'h1);
        chk("abort done", 32'(dn[0]), 32'h0);
        summarize();
    end

    // Watchdog well beyond the few hundred cycles the scenarios need
    initial begin
        repeat (20000) @(posedge sys_clk);
        n_fail++;
        summarize();
    end
endmodule
